// File: src/relay_ctl.sv
// alarm evaluation, output logic functions, relay timing and register slave
`timescale 1ns/1ps
`default_nettype none
module relay_ctl #(
    parameter int TICK_DIV = relay_ctl_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // apb slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // channel measurement results, signed
    input wire logic [relay_ctl_pkg::NUM_CH-1:0][15:0] chan_value_in,
    // relays and interrupt
    output logic [relay_ctl_pkg::NUM_OUT-1:0] relay_closed_out,
    output logic irq_out
);
    import relay_ctl_pkg::*;

    function automatic logic in_block(input logic [7:0] a, input logic [7:0] base, input int n);
        logic [8:0] lim;
        lim = {1'b0, base} + 9'(n * 4);
        return a[1:0] == 2'b00 && a >= base && {1'b0, a} < lim;
    endfunction : in_block

    function automatic int word_idx(input logic [7:0] a, input logic [7:0] base);
        logic [7:0] d;
        d = a - base;
        return int'(d[7:2]);
    endfunction : word_idx

    out_cfg_s [NUM_OUT-1:0] cfg_ff;
    out_time_s [NUM_OUT-1:0] dly_ff;
    out_time_s [NUM_OUT-1:0] hold_ff;
    alm_cfg_s [NUM_ALM-1:0] alm_cfg_ff;
    logic [NUM_ALM-1:0] alarm_ff;
    logic [NUM_CH-1:0] chan_state;
    logic [NUM_OUT-1:0] logic_res;
    logic [NUM_OUT-1:0] relay_q;
    logic [NUM_OUT-1:0] relay_prev_ff;
    logic [NUM_ALM-1:0] alarm_prev_ff;
    logic [INT_W-1:0] int_stat_ff;
    logic [INT_W-1:0] int_mask_ff;
    logic [INT_W-1:0] events;
    logic [INT_W-1:0] stat_kept;
    logic [31:0] tick_cnt_ff;
    logic tick_ff;
    logic acc;
    logic wr;
    logic rd_clr;
    logic hit;
    logic [31:0] rd_val;

    // tick divider: slow rate as a one-cycle enable
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b0;
        end else if (tick_cnt_ff >= 32'(TICK_DIV - 1)) begin
            tick_cnt_ff <= 32'h0000_0000;
            tick_ff <= 1'b1;
        end else begin
            tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
            tick_ff <= 1'b0;
        end
    end

    // alarm comparators with hysteresis band
    genvar ga;
    generate
        for (ga = 0; ga < NUM_ALM; ga++) begin : g_alm
            logic signed [17:0] val;
            logic signed [17:0] hi;
            logic signed [17:0] lo;
            assign val = 18'(signed'(chan_value_in[ga / 2]));
            assign hi = 18'(signed'(alm_cfg_ff[ga].thr)) + signed'({10'h000, alm_cfg_ff[ga].hys});
            assign lo = 18'(signed'(alm_cfg_ff[ga].thr)) - signed'({10'h000, alm_cfg_ff[ga].hys});
            always_ff @(posedge mclk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    alarm_ff[ga] <= 1'b0;
                end else begin
                    unique case (alm_cfg_ff[ga].mode)
                        ALM_OVER: begin
                            if (val >= hi) begin
                                alarm_ff[ga] <= 1'b1;
                            end else if (val <= lo) begin
                                alarm_ff[ga] <= 1'b0;
                            end
                        end
                        ALM_UNDER: begin
                            if (val <= lo) begin
                                alarm_ff[ga] <= 1'b1;
                            end else if (val >= hi) begin
                                alarm_ff[ga] <= 1'b0;
                            end
                        end
                        default: begin
                            alarm_ff[ga] <= 1'b0;
                        end
                    endcase
                end
            end

            AST_OVER_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (alm_cfg_ff[ga].mode == ALM_OVER && val >= hi) |=> alarm_ff[ga])
                else $error("over alarm not set above band");

            AST_UNDER_SET: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (alm_cfg_ff[ga].mode == ALM_UNDER && val <= lo) ##1 (alm_cfg_ff[ga].mode == ALM_UNDER)
                |-> alarm_ff[ga])
                else $error("under alarm not set below band");

            AST_OVER_CLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (alm_cfg_ff[ga].mode == ALM_OVER && val < hi && val <= lo) |=> !alarm_ff[ga])
                else $error("over alarm not cleared below band");

            AST_UNDER_CLR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (alm_cfg_ff[ga].mode == ALM_UNDER && val > lo && val >= hi) |=> !alarm_ff[ga])
                else $error("under alarm not cleared above band");

            AST_ALM_OFF: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (alm_cfg_ff[ga].mode != ALM_OVER && alm_cfg_ff[ga].mode != ALM_UNDER)
                |=> !alarm_ff[ga])
                else $error("disabled alarm is set");
        end
    endgenerate

    // channel alarm state from the source selector of each output
    genvar go;
    generate
        for (go = 0; go < NUM_OUT; go++) begin : g_out
            logic [NUM_CH-1:0] att;
            logic [NUM_CH-1:0] st;
            for (genvar gc = 0; gc < NUM_CH; gc++) begin : g_ch
                always_comb begin
                    att[gc] = cfg_ff[go].src[gc] != SRC_NONE;
                    unique case (cfg_ff[go].src[gc])
                        SRC_AL1: st[gc] = alarm_ff[2 * gc];
                        SRC_AL2: st[gc] = alarm_ff[2 * gc + 1];
                        SRC_BOTH: st[gc] = alarm_ff[2 * gc] & alarm_ff[2 * gc + 1];
                        SRC_NONE: st[gc] = 1'b0;
                    endcase
                end

                AST_SRC_SINGLE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                    (cfg_ff[go].src[gc] == SRC_AL2) |-> (st[gc] == alarm_ff[2 * gc + 1]))
                    else $error("single source channel state wrong");

                AST_SRC_A1: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                    (cfg_ff[go].src[gc] == SRC_AL1) |-> (st[gc] == alarm_ff[2 * gc]))
                    else $error("first alarm source channel state wrong");

                AST_SRC_BOTH: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                    (cfg_ff[go].src[gc] == SRC_BOTH && st[gc]) |-> (alarm_ff[2 * gc] && alarm_ff[2 * gc + 1]))
                    else $error("both source set without both alarms");
            end
            // an output with no attached channel never asserts
            assign logic_res[go] = cfg_ff[go].and_fn ?
                (att != '0 && (st & att) == att) :
                ((st & att) != '0);

            AST_OR_FN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (!cfg_ff[go].and_fn && (st & att) != '0) |-> logic_res[go])
                else $error("or function missed an attached alarm");

            AST_AND_FN: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (cfg_ff[go].and_fn && logic_res[go]) |-> ((st & att) == att && att != '0))
                else $error("and function set without all alarms");

            AST_NO_SOURCE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
                (cfg_ff[go].src == '0) |-> !logic_res[go])
                else $error("output without sources asserted");

            relay_timer u_timer (
                .mclk_in(mclk_in),
                .rst_b_in(rst_b_in),
                .tick_in(tick_ff),
                .logic_in(logic_res[go]),
                .nc_in(cfg_ff[go].nc),
                .dly_in(dly_ff[go]),
                .hold_in(hold_ff[go]),
                .relay_closed_out(relay_q[go])
            );
        end
    endgenerate

    assign relay_closed_out = relay_q;

    // apb: one wait state so read data come from a flop
    assign acc = psel_in && penable_in && pready_out;
    assign wr = acc && pwrite_in;
    assign rd_clr = acc && !pwrite_in && paddr_in == INT_STAT_OFS;
    assign hit = paddr_in == STATUS_OFS || paddr_in == INT_STAT_OFS || paddr_in == INT_MASK_OFS
        || in_block(paddr_in, OUT_CFG_OFS, NUM_OUT) || in_block(paddr_in, OUT_DLY_OFS, NUM_OUT)
        || in_block(paddr_in, OUT_HOLD_OFS, NUM_OUT) || in_block(paddr_in, ALM_CFG_OFS, NUM_ALM);

    always_comb begin
        rd_val = RESET_VAL;
        if (paddr_in == STATUS_OFS) begin
            rd_val[ST_RELAY_LSB +: NUM_OUT] = relay_q;
            rd_val[ST_ALM_LSB +: NUM_ALM] = alarm_ff;
        end else if (paddr_in == INT_STAT_OFS) begin
            rd_val[INT_W-1:0] = int_stat_ff;
        end else if (paddr_in == INT_MASK_OFS) begin
            rd_val[INT_W-1:0] = int_mask_ff;
        end else if (in_block(paddr_in, OUT_CFG_OFS, NUM_OUT)) begin
            rd_val[CFG_SRC_LSB + 2 * NUM_CH - 1:0] = cfg_ff[word_idx(paddr_in, OUT_CFG_OFS)];
        end else if (in_block(paddr_in, OUT_DLY_OFS, NUM_OUT)) begin
            rd_val = dly_ff[word_idx(paddr_in, OUT_DLY_OFS)];
        end else if (in_block(paddr_in, OUT_HOLD_OFS, NUM_OUT)) begin
            rd_val = hold_ff[word_idx(paddr_in, OUT_HOLD_OFS)];
        end else if (in_block(paddr_in, ALM_CFG_OFS, NUM_ALM)) begin
            rd_val[ALM_MODE_LSB + 1:0] = alm_cfg_ff[word_idx(paddr_in, ALM_CFG_OFS)];
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= RESET_VAL;
        end else if (psel_in && penable_in && !pready_out) begin
            pready_out <= 1'b1;
            pslverr_out <= !hit;
            prdata_out <= (pwrite_in || !hit) ? RESET_VAL : rd_val;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    AST_ONE_WAIT: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (psel_in && penable_in && !pready_out) |=> pready_out)
        else $error("access not answered after one wait state");

    AST_READY_PULSE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");

    AST_ERR_UNMAPPED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (psel_in && penable_in && !pready_out && !hit) |=> pslverr_out)
        else $error("unmapped access not flagged");

    AST_ERR_WITH_READY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        pslverr_out |-> pready_out)
        else $error("error flag without ready");

    // configuration writes
    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cfg_ff <= '0;
            dly_ff <= '0;
            hold_ff <= '0;
            alm_cfg_ff <= '0;
            int_mask_ff <= '0;
        end else if (wr) begin
            if (paddr_in == INT_MASK_OFS) begin
                int_mask_ff <= pwdata_in[INT_W-1:0];
            end
            if (in_block(paddr_in, OUT_CFG_OFS, NUM_OUT)) begin
                cfg_ff[word_idx(paddr_in, OUT_CFG_OFS)] <= pwdata_in[CFG_SRC_LSB + 2 * NUM_CH - 1:0];
            end
            if (in_block(paddr_in, OUT_DLY_OFS, NUM_OUT)) begin
                dly_ff[word_idx(paddr_in, OUT_DLY_OFS)] <= pwdata_in;
            end
            if (in_block(paddr_in, OUT_HOLD_OFS, NUM_OUT)) begin
                hold_ff[word_idx(paddr_in, OUT_HOLD_OFS)] <= pwdata_in;
            end
            if (in_block(paddr_in, ALM_CFG_OFS, NUM_ALM)) begin
                alm_cfg_ff[word_idx(paddr_in, ALM_CFG_OFS)] <= pwdata_in[ALM_MODE_LSB + 1:0];
            end
        end
    end

    // events: relay toggles and alarm onsets; a new event beats the read clear
    assign events = {alarm_ff & ~alarm_prev_ff, relay_q ^ relay_prev_ff};
    // a read clears only the bits it returned: an onset between data capture
    // and the access edge would otherwise be lost
    assign stat_kept = rd_clr ? (int_stat_ff & ~prdata_out[INT_W-1:0]) : int_stat_ff;

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            relay_prev_ff <= '0;
            alarm_prev_ff <= '0;
            int_stat_ff <= '0;
            irq_out <= 1'b0;
        end else begin
            relay_prev_ff <= relay_q;
            alarm_prev_ff <= alarm_ff;
            int_stat_ff <= stat_kept | events;
            irq_out <= ((stat_kept | events) & int_mask_ff) != '0;
        end
    end

    AST_EVENT_STICKY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (events != '0) |=> ((int_stat_ff & $past(events)) == $past(events)))
        else $error("event not latched in status");

    AST_READ_CLEAR: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (rd_clr && events == '0) |=> ((int_stat_ff & $past(prdata_out[INT_W-1:0])) == '0))
        else $error("status bits read but not cleared");

    AST_IRQ_LEVEL: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        !$past(wr) |-> irq_out == ((int_stat_ff & int_mask_ff) != '0))
        else $error("interrupt does not match masked status");

    sequence s_tick;
        tick_ff;
    endsequence
    sequence s_quiet;
        !tick_ff ##1 !tick_ff;
    endsequence

    AST_TICK_SPACING: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s_tick |=> s_quiet)
        else $error("timer ticks too close together");

    AST_TICK_RESTART: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        tick_ff |-> tick_cnt_ff == 32'h0000_0000)
        else $error("tick divider did not restart on tick");

    AST_STATUS_RELAY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == STATUS_OFS)
        |=> prdata_out[ST_RELAY_LSB +: NUM_OUT] == $past(relay_q))
        else $error("status read does not show relay state");
endmodule : relay_ctl
`default_nettype wire

// File: src/relay_ctl_pkg.sv
// shared constants, register map and carrier types of the relay output controller
package relay_ctl_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_OUT = 2;
    localparam int NUM_ALM = NUM_CH * 2;
    // timer tick: one tenth of a second at a 10 ns clock
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] STATUS_OFS = 8'h00;
    localparam logic [7:0] INT_STAT_OFS = 8'h04;
    localparam logic [7:0] INT_MASK_OFS = 8'h08;
    localparam logic [7:0] OUT_CFG_OFS = 8'h10;
    localparam logic [7:0] OUT_DLY_OFS = 8'h18;
    localparam logic [7:0] OUT_HOLD_OFS = 8'h20;
    localparam logic [7:0] ALM_CFG_OFS = 8'h40;
    // field positions
    localparam int ST_RELAY_LSB = 0;
    localparam int ST_ALM_LSB = 2;
    localparam int INT_W = NUM_OUT + NUM_ALM;
    localparam int CFG_NC_BIT = 0;
    localparam int CFG_AND_BIT = 1;
    localparam int CFG_SRC_LSB = 2;
    localparam int ALM_THR_LSB = 0;
    localparam int ALM_HYS_LSB = 16;
    localparam int ALM_MODE_LSB = 24;
    localparam logic [31:0] RESET_VAL = 32'h0000_0000;
    // channel source selector codes
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_AL1 = 2'h1;
    localparam logic [1:0] SRC_AL2 = 2'h2;
    localparam logic [1:0] SRC_BOTH = 2'h3;
    // alarm condition codes
    localparam logic [1:0] ALM_OFF = 2'h0;
    localparam logic [1:0] ALM_OVER = 2'h1;
    localparam logic [1:0] ALM_UNDER = 2'h2;

    typedef struct packed {
        logic [NUM_CH-1:0][1:0] src;
        logic and_fn;
        logic nc;
    } out_cfg_s;

    typedef struct packed {
        logic [15:0] open_t;
        logic [15:0] close_t;
    } out_time_s;

    typedef struct packed {
        logic [1:0] mode;
        logic [7:0] hys;
        logic [15:0] thr;
    } alm_cfg_s;
endpackage : relay_ctl_pkg

// File: src/relay_timer.sv
// per-output switching delay, hold time and relay drive
`timescale 1ns/1ps
`default_nettype none
module relay_timer (
    // clock and reset
    input wire logic mclk_in,
    input wire logic rst_b_in,
    // timing and control
    input wire logic tick_in,
    input wire logic logic_in,
    input wire logic nc_in,
    input wire relay_ctl_pkg::out_time_s dly_in,
    input wire relay_ctl_pkg::out_time_s hold_in,
    // relay
    output logic relay_closed_out
);
    import relay_ctl_pkg::*;

    logic act_ff;
    logic [15:0] cnt_ff;
    logic [15:0] hold_ff;
    logic nxt_act;
    logic [15:0] nxt_cnt;
    logic [15:0] nxt_hold;
    logic sw;
    logic cur_closed;
    logic [15:0] sw_dly;
    logic [15:0] sw_hold;

    assign cur_closed = act_ff ^ nc_in;
    // leaving closed uses the open delay, leaving open the close delay
    assign sw_dly = cur_closed ? dly_in.open_t : dly_in.close_t;
    assign sw_hold = cur_closed ? hold_in.open_t : hold_in.close_t;

    always_comb begin
        nxt_act = act_ff;
        nxt_cnt = cnt_ff;
        nxt_hold = hold_ff;
        sw = 1'b0;
        if (hold_ff != 16'h0000) begin
            // alarms ignored and counting frozen during hold
            if (tick_in) begin
                nxt_hold = hold_ff - 16'h0001;
            end
        end else if (logic_in != act_ff) begin
            if (sw_dly == 16'h0000) begin
                sw = 1'b1;
            end else if (tick_in) begin
                if ({1'b0, cnt_ff} + 17'h00001 >= {1'b0, sw_dly}) begin
                    sw = 1'b1;
                end else begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
        end else if (tick_in && cnt_ff != 16'h0000) begin
            nxt_cnt = cnt_ff - 16'h0001;
        end
        if (sw) begin
            nxt_act = ~act_ff;
            nxt_cnt = 16'h0000;
            nxt_hold = sw_hold;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            act_ff <= 1'b0;
            cnt_ff <= 16'h0000;
            hold_ff <= 16'h0000;
        end else begin
            act_ff <= nxt_act;
            cnt_ff <= nxt_cnt;
            hold_ff <= nxt_hold;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            relay_closed_out <= 1'b0;
        end else begin
            relay_closed_out <= nxt_act ^ nc_in;
        end
    end

    AST_HOLD_FREEZE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (hold_ff != 16'h0000) |=> (act_ff == $past(act_ff)))
        else $error("relay state changed during hold");

    AST_ZERO_DELAY: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (hold_ff == 16'h0000 && logic_in != act_ff && sw_dly == 16'h0000) |=> act_ff != $past(act_ff))
        else $error("zero delay did not switch at once");

    AST_DELAY_ELAPSED: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (act_ff != $past(act_ff)) |-> $past(sw_dly == 16'h0000 || (tick_in && cnt_ff + 16'h0001 >= sw_dly)))
        else $error("relay switched before delay elapsed");

    AST_COUNT_UP: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (hold_ff == 16'h0000 && logic_in != act_ff && tick_in && sw_dly != 16'h0000
         && {1'b0, cnt_ff} + 17'h00001 < {1'b0, sw_dly}) |=> cnt_ff == $past(cnt_ff) + 16'h0001)
        else $error("delay counter did not count up");

    sequence s_stable_no;
        !nc_in ##1 !nc_in;
    endsequence
    sequence s_stable_nc;
        nc_in ##1 nc_in;
    endsequence

    AST_NO_MODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s_stable_no |-> relay_closed_out == act_ff)
        else $error("normally open relay does not follow logic state");

    AST_NC_MODE: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        s_stable_nc |-> relay_closed_out == !act_ff)
        else $error("normally closed relay does not invert logic state");
endmodule : relay_timer
`default_nettype wire

// File: test/relay_ctl_tb_top.sv
// register level tests of the relay output controller
`timescale 1ns/1ps
`default_nettype none
module relay_ctl_tb_top;
    import relay_ctl_pkg::*;
    localparam int TD = 4;
    logic mclk_in = 0, rst_b_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata_out, q;
    logic pready_out, pslverr_out, irq_out, err;
    logic [NUM_CH-1:0][15:0] chan = '0;
    logic [NUM_OUT-1:0] relay_closed_out, load_on;
    int num_errors = 0, n_compared = 0, c;
    always #5 mclk_in = ~mclk_in;
    relay_ctl #(.TICK_DIV(TD)) dut (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
        .chan_value_in(chan), .relay_closed_out(relay_closed_out), .irq_out(irq_out));
    relay_load loads (.relay_closed_in(relay_closed_out), .load_on_out(load_on));
    task automatic end_sim();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // ready, data and error are taken at the rising edge that sees ready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_in);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk_in);
            i++;
        end while (pready_out !== 1'b1 && i < 20);
        if (pready_out !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        q = prdata_out;
        err = pslverr_out;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        chk("write error", {31'h0, err}, 32'h0);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("read data", q, exp);
    endtask : rd
    task automatic setv(input int ch, input logic [15:0] v);
        @(posedge mclk_in);
        chan[ch] <= v;
    endtask : setv
    // counts cycles until relay o shows v; a miss after n cycles ends the run
    task automatic wait_rly(input int o, input logic v, input int n);
        c = 0;
        while (relay_closed_out[o] !== v && c < n) begin
            @(negedge mclk_in);
            c++;
        end
        if (relay_closed_out[o] !== v) begin
            num_errors++;
            end_sim();
        end
    endtask : wait_rly
    // counts cycles for which relay o stays at v, up to n
    task automatic keep_rly(input int o, input logic v, input int n);
        c = 0;
        while (relay_closed_out[o] === v && c < n) begin
            @(negedge mclk_in);
            c++;
        end
    endtask : keep_rly
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_b_in <= 1'b1;
        rd(STATUS_OFS, RESET_VAL);
        apb(1'b0, 8'h3c, 32'h0);
        chk("unmapped error", {31'h0, err}, 32'h1);
        chk("unmapped data", q, 32'h0);
        wr(INT_MASK_OFS, 32'h3);
        wr(ALM_CFG_OFS, 32'h010a_0064);
        wr(ALM_CFG_OFS + 8'h04, 32'h020a_0064);
        wr(OUT_CFG_OFS, 32'h4);
        setv(0, 16'd109);
        keep_rly(0, 1'b0, 20);
        chk("relay0 below band", c, 20);
        setv(0, 16'd110);
        wait_rly(0, 1'b1, 10);
        chk("relay0 closes", relay_closed_out[0], 1);
        chk("load0 on", load_on[0], 1);
        repeat (3) @(negedge mclk_in);
        chk("irq raised", irq_out, 1);
        rd(STATUS_OFS, 32'h5);
        rd(INT_STAT_OFS, 32'hd);
        rd(INT_STAT_OFS, 32'h0);
        chk("irq cleared", irq_out, 0);
        setv(0, 16'd90);
        wait_rly(0, 1'b0, 10);
        chk("alarm2 ignored", relay_closed_out[0], 0);
        wr(ALM_CFG_OFS + 8'h04, 32'h0100_00c8);
        wr(OUT_CFG_OFS, 32'hc);
        setv(0, 16'd250);
        wait_rly(0, 1'b1, 10);
        chk("both alarms close", relay_closed_out[0], 1);
        wr(ALM_CFG_OFS + 8'h04, 32'h0);
        wait_rly(0, 1'b0, 10);
        chk("one alarm opens", relay_closed_out[0], 0);
        wr(ALM_CFG_OFS + 8'h08, 32'h0100_0032);
        wr(OUT_CFG_OFS + 8'h04, 32'h16);
        keep_rly(1, 1'b0, 20);
        chk("and one missing", c, 20);
        setv(1, 16'd60);
        wait_rly(1, 1'b1, 10);
        chk("and all present", relay_closed_out[1], 1);
        wr(OUT_CFG_OFS + 8'h04, 32'h14);
        setv(0, 16'd0);
        keep_rly(1, 1'b1, 20);
        chk("or keeps relay", c, 20);
        wr(OUT_CFG_OFS + 8'h04, 32'h15);
        wait_rly(1, 1'b0, 10);
        chk("nc opens", relay_closed_out[1], 0);
        setv(1, 16'd0);
        wait_rly(1, 1'b1, 10);
        chk("nc closes", relay_closed_out[1], 1);
        wr(OUT_CFG_OFS, 32'h4);
        wr(OUT_DLY_OFS, 32'h3);
        setv(0, 16'd200);
        wait_rly(0, 1'b1, 40);
        chk("close delay floor", c >= 2 * TD, 1);
        chk("close delay ends", relay_closed_out[0], 1);
        wr(OUT_DLY_OFS, 32'h0);
        wr(OUT_HOLD_OFS, 32'ha);
        setv(0, 16'd0);
        wait_rly(0, 1'b0, 10);
        setv(0, 16'd200);
        wait_rly(0, 1'b1, 10);
        setv(0, 16'd0);
        wait_rly(0, 1'b0, 80);
        chk("hold time kept", c >= 8 * TD, 1);
        chk("hold time ends", relay_closed_out[0], 0);
        end_sim();
    end
endmodule : relay_ctl_tb_top
`default_nettype wire

// File: test/relay_load.sv
// behavioural model of the loads switched by the relay outputs
`timescale 1ns/1ps
`default_nettype none
module relay_load (
    // relay contacts
    input wire logic [relay_ctl_pkg::NUM_OUT-1:0] relay_closed_in,
    // load supply
    output logic [relay_ctl_pkg::NUM_OUT-1:0] load_on_out
);
    import relay_ctl_pkg::*;
    // open contact leaves the load line to its pull-down
    assign load_on_out = relay_closed_in;
endmodule : relay_load
`default_nettype wire
